// ===== common/fse_pkg.sv
// Shared constants, carrier types and code functions for the flash array check logic.
package fse_pkg;

  // ---------------------------------------------------------------------------
  // Geometry and widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W         = 32;
  localparam int DATA_W         = 128;
  localparam int UNIT_BYTES     = 16;
  localparam int HAM_W          = 8;
  localparam int CODE_W         = 9;
  localparam int UNIT_LSB       = 4;
  localparam int UNIT_W         = 6;
  localparam int NUM_UNITS      = 64;
  localparam int SEC_W          = 2;
  localparam int SEC_SHIFT_W    = 4;
  localparam int STAT_W         = 8;
  localparam int CNT_W          = 16;

  // ---------------------------------------------------------------------------
  // Field positions and values
  // ---------------------------------------------------------------------------
  localparam int CFG_DED_BIT    = 3;
  localparam int UST_DOUBLE_BIT = 3;
  localparam int UST_CORR_BIT   = 1;
  localparam int UST_OFF_BIT    = 0;
  localparam int EST_SINGLE_BIT = 3;
  localparam int EST_DOUBLE_BIT = 4;
  localparam logic [CNT_W-1:0]     CNT_MAX     = 16'hFFFF;
  localparam logic [7:0]           ERASED_BYTE = 8'hFF;
  localparam logic [NUM_UNITS-1:0] SECTOR_ONES = 64'h000000000000FFFF;
  localparam logic [STAT_W-1:0]    STAT_RESET  = 8'h00;
  localparam logic [ADDR_W-1:0]    ADDR_RESET  = 32'h00000000;

  // One corrected read word as it waits for the receiver.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              single_err;
    logic              double_err;
  } fse_rd_word_t;

  localparam int WORD_W = $bits(fse_rd_word_t);

  // Hamming check bits over the unit plus one overall parity bit on top.
  function automatic logic [CODE_W-1:0] fse_encode(input logic [DATA_W-1:0] d);
    logic [CODE_W-1:0] c;
    int                p;
    c = '0;
    p = 3;
    for (int i = 0; i < DATA_W; i++) begin
      for (int j = 0; j < HAM_W; j++) begin
        if (p[j]) begin
          c[j] = c[j] ^ d[i];
        end
      end
      p = p + 1;
      if ((p & (p - 1)) == 0) begin
        p = p + 1;
      end
    end
    c[HAM_W] = ^{d, c[HAM_W-1:0]};
    return c;
  endfunction : fse_encode

  // Flips the data bit whose code position equals the syndrome.
  function automatic logic [DATA_W-1:0] fse_fix(input logic [DATA_W-1:0] d,
                                                input logic [HAM_W-1:0]  syn);
    logic [DATA_W-1:0] r;
    int                p;
    r = d;
    p = 3;
    for (int i = 0; i < DATA_W; i++) begin
      if (p[HAM_W-1:0] == syn) begin
        r[i] = ~d[i];
      end
      p = p + 1;
      if ((p & (p - 1)) == 0) begin
        p = p + 1;
      end
    end
    return r;
  endfunction : fse_fix

endpackage : fse_pkg

// ===== core/fse_pair_buf.sv
// Two-entry valid/ready buffer whose head entry drives the outputs from flops.
module fse_pair_buf
  import fse_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_in_valid,
  input  wire logic [WORD_W-1:0] i_in_word,
  output logic                   o_in_ready,
  output logic                   o_out_valid,
  output logic      [WORD_W-1:0] o_out_word,
  input  wire logic              i_out_ready,
  output logic      [1:0]        o_count
);

  logic              tail_v;
  logic [WORD_W-1:0] tail;
  logic              push;
  logic              pop;

  assign push    = i_in_valid && o_in_ready;
  assign pop     = o_out_valid && i_out_ready;
  assign o_count = {1'b0, o_out_valid} + {1'b0, tail_v};

  // ---------------------------------------------------------------------------
  // Head and tail entries
  // ---------------------------------------------------------------------------
  // The head refills from the tail first so words leave in arrival order.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_out_valid <= 1'b0;
      o_out_word  <= '0;
      tail_v      <= 1'b0;
      tail        <= '0;
    end else if (pop || !o_out_valid) begin
      if (tail_v) begin
        o_out_valid <= 1'b1;
        o_out_word  <= tail;
        tail_v      <= push;
        if (push) begin
          tail <= i_in_word;
        end
      end else begin
        o_out_valid <= push;
        if (push) begin
          o_out_word <= i_in_word;
        end
      end
    end else if (push) begin
      tail   <= i_in_word;
      tail_v <= 1'b1;
    end
  end

  // Ready is a flop; it drops once the tail fills, except when a pop and a push refill the tail in one cycle.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_in_ready <= 1'b0;
    end else begin
      o_in_ready <= !(tail_v && !pop) && !(push && o_out_valid && !pop);
    end
  end

endmodule : fse_pair_buf

// ===== core/fse_ecc_core.sv
// Check code generation, read correction and error reporting for the flash array.
//
// What this block does
// RULE1: Codes are built and checked over fixed 16-byte units with a Hamming code.
// RULE2: Each unit written to its 128-bit line also stores its hidden check code.
// RULE3: Every array read checks the stored code and fixes one-bit errors first.
// RULE4: The first program into an erased unit sets the code for the whole unit.
// RULE5: In single mode a repeat program turns checking off; sector erase restores it.
// RULE6: Double detection mode is default and uses a 9-bit code per unit.
// RULE7: In double mode a repeat program without erase is refused with an error.
// RULE8: Host erases every sector before changing detection mode.
// RULE9: The status transaction returns the 8-bit status of the addressed unit.
// RULE10: Status bit 3 shows a double error only while config bit 3 is set.
// RULE11: In double mode a refused repeat program leaves the checking-off flag clear.
// RULE12: Status bit 1 shows that a one-bit error was corrected in the unit.
// RULE13: Status bit 0 shows that checking is off for the unit.
// RULE14: Status bits 7 to 4 and bit 2 always read zero.
// RULE15: A status register accumulates single and double errors since the last clear.
// RULE16: The trap register keeps the address of the first error after a clear.
// RULE17: A counter adds up the single and double errors found during reads.
// RULE18: The 16-bit error counter stops at its maximum and never wraps.
// RULE19: Reset or the clear transaction clears status, trap and counter.
// RULE20: A unit in error counts once per read transaction, again in later ones.
// RULE21: An overall parity bit separates one-bit from two-bit syndromes.
module fse_ecc_core
  import fse_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_arst_n,
  input  wire logic [STAT_W-1:0]   i_config_reg4_volatile,
  input  wire logic                i_prog_valid,
  input  wire logic [ADDR_W-1:0]   i_prog_addr,
  input  wire logic [DATA_W-1:0]   i_prog_data,
  input  wire logic [UNIT_BYTES-1:0] i_prog_bmask,
  output logic                     o_prog_done,
  output logic                     o_prog_error,
  output logic                     o_arr_wr_en,
  output logic      [UNIT_W-1:0]   o_arr_wr_unit,
  output logic      [DATA_W-1:0]   o_arr_wr_data,
  output logic      [CODE_W-1:0]   o_arr_wr_code,
  input  wire logic                i_erase_valid,
  input  wire logic [SEC_W-1:0]    i_erase_sector,
  input  wire logic                i_rd_valid,
  input  wire logic                i_rd_start,
  input  wire logic [ADDR_W-1:0]   i_rd_addr,
  output logic                     o_rd_ready,
  output logic                     o_arr_rd_en,
  output logic      [UNIT_W-1:0]   o_arr_rd_unit,
  input  wire logic [DATA_W-1:0]   i_arr_rd_data,
  input  wire logic [CODE_W-1:0]   i_arr_rd_code,
  output logic                     o_rd_valid,
  output fse_rd_word_t             o_rd_word,
  input  wire logic                i_rd_out_ready,
  input  wire logic                i_stat_valid,
  input  wire logic [ADDR_W-1:0]   i_stat_addr,
  output logic                     o_stat_valid,
  output logic      [STAT_W-1:0]   o_data_unit_check_status,
  input  wire logic                i_clear_status,
  output logic      [STAT_W-1:0]   o_ecc_status,
  output logic      [ADDR_W-1:0]   o_trap_addr,
  output logic      [CNT_W-1:0]    o_err_count
);

  // ---------------------------------------------------------------------------
  // Per-unit state and shared decode
  // ---------------------------------------------------------------------------
  logic [NUM_UNITS-1:0] programmed;
  logic [NUM_UNITS-1:0] check_off;
  logic [NUM_UNITS-1:0] single_seen;
  logic [NUM_UNITS-1:0] double_seen;
  logic [NUM_UNITS-1:0] counted;
  logic [NUM_UNITS-1:0] erase_mask;
  logic                 ded_mode;
  logic [UNIT_W-1:0]    prog_unit;
  logic                 prog_repeat;
  logic                 prog_reject;
  logic                 prog_take;
  logic [DATA_W-1:0]    merged;
  logic [CODE_W-1:0]    merged_code;

  assign ded_mode    = i_config_reg4_volatile[CFG_DED_BIT];
  assign prog_unit   = i_prog_addr[UNIT_LSB +: UNIT_W];
  assign prog_repeat = programmed[prog_unit];
  assign prog_reject = i_prog_valid && ded_mode && prog_repeat; // RULE7
  assign prog_take   = i_prog_valid && !prog_reject;
  assign merged_code = fse_encode(merged);
  assign erase_mask  = i_erase_valid ? (SECTOR_ONES << {i_erase_sector, 4'h0}) : '0;

  // Bytes the host did not write stay erased so the code covers the whole unit.
  always_comb begin
    merged = '0;
    for (int b = 0; b < UNIT_BYTES; b++) begin
      merged[b*8 +: 8] = i_prog_bmask[b] ? i_prog_data[b*8 +: 8] : ERASED_BYTE; // RULE4
    end
  end

  // ---------------------------------------------------------------------------
  // Program path
  // ---------------------------------------------------------------------------
  // The code is written with the data; in single mode the parity bit is unused.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_arr_wr_en   <= 1'b0;
      o_arr_wr_unit <= '0;
      o_arr_wr_data <= '0;
      o_arr_wr_code <= '0;
      o_prog_done   <= 1'b0;
      o_prog_error  <= 1'b0;
    end else begin
      o_arr_wr_en  <= prog_take; // RULE2
      o_prog_done  <= prog_take;
      o_prog_error <= prog_reject; // RULE7
      if (prog_take) begin
        o_arr_wr_unit <= prog_unit;
        o_arr_wr_data <= merged; // RULE1
        o_arr_wr_code <= ded_mode ? merged_code : {1'b0, merged_code[HAM_W-1:0]}; // RULE6
      end
    end
  end

  // Erase clears a sector's units; a program in the same cycle still marks its unit.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      programmed <= '0;
    end else begin
      programmed <= (programmed & ~erase_mask) |
                    (prog_take ? (NUM_UNITS'(1) << prog_unit) : '0);
    end
  end

  // Only single mode disables checking; a refused double-mode repeat leaves it clear.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      check_off <= '0;
    end else begin
      check_off <= (check_off & ~erase_mask) | // RULE5
                   ((prog_take && prog_repeat && !ded_mode) ? // RULE11
                    (NUM_UNITS'(1) << prog_unit) : '0);
    end
  end

  // ---------------------------------------------------------------------------
  // Read path: request, array access, decode
  // ---------------------------------------------------------------------------
  logic              rd_take;
  logic              st2;
  logic [ADDR_W-1:0] addr1;
  logic [ADDR_W-1:0] addr2;
  logic [UNIT_W-1:0] unit2;
  logic [HAM_W-1:0]  calc_syn;
  logic              par_err;
  logic              unit_on;
  logic              err_single;
  logic              err_double;
  logic              err_any;
  logic              err_new;
  logic [DATA_W-1:0] fixed_data;
  logic [CODE_W-1:0] rd_code_calc;
  logic [CODE_W-1:0] wr_code_calc;
  logic              buf_ready;
  logic [1:0]        buf_count;
  logic              buf_pop;
  logic [2:0]        occ_next;
  fse_rd_word_t      push_word;

  assign rd_take  = i_rd_valid && o_rd_ready;
  assign unit2    = addr2[UNIT_LSB +: UNIT_W];
  // A function result cannot be sliced directly, so both codes are held in nets first.
  assign rd_code_calc = fse_encode(i_arr_rd_data);
  assign wr_code_calc = fse_encode(o_arr_wr_data);
  assign calc_syn = i_arr_rd_code[HAM_W-1:0] ^ rd_code_calc[HAM_W-1:0];
  assign par_err  = ^{i_arr_rd_data, i_arr_rd_code}; // RULE21
  assign unit_on  = !check_off[unit2];
  assign err_single = st2 && unit_on && (ded_mode ? par_err : (calc_syn != '0)); // RULE21
  assign err_double = st2 && unit_on && ded_mode && !par_err && (calc_syn != '0); // RULE6
  assign err_any    = err_single || err_double;
  assign err_new    = err_any && !counted[unit2]; // RULE20
  assign fixed_data = (err_single && (calc_syn != '0)) ?
                      fse_fix(i_arr_rd_data, calc_syn) : i_arr_rd_data; // RULE3
  assign buf_pop  = o_rd_valid && i_rd_out_ready;
  assign occ_next = {1'b0, buf_count} + {2'b00, st2} - {2'b00, buf_pop};

  always_comb begin
    push_word            = '0;
    push_word.addr       = addr2;
    push_word.data       = fixed_data;
    push_word.single_err = err_single;
    push_word.double_err = err_double;
  end

  // A read is taken only when its word is sure to find room two cycles later.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_ready    <= 1'b0;
      o_arr_rd_en   <= 1'b0;
      o_arr_rd_unit <= '0;
      addr1         <= '0;
      st2           <= 1'b0;
      addr2         <= '0;
    end else begin
      o_rd_ready  <= !rd_take && !o_arr_rd_en && (occ_next < 3'h2);
      o_arr_rd_en <= rd_take;
      st2         <= o_arr_rd_en;
      addr2       <= addr1;
      if (rd_take) begin
        addr1         <= i_rd_addr;
        o_arr_rd_unit <= i_rd_addr[UNIT_LSB +: UNIT_W];
      end
    end
  end

  // Units already counted in this transaction; a new transaction starts fresh.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      counted <= '0;
    end else if (rd_take && i_rd_start) begin
      counted <= '0; // RULE20
    end else if (err_any) begin
      counted <= counted | (NUM_UNITS'(1) << unit2);
    end
  end

  // Per-unit error flags last until the sector is erased.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      single_seen <= '0;
      double_seen <= '0;
    end else begin
      single_seen <= (single_seen & ~erase_mask) |
                     (err_single ? (NUM_UNITS'(1) << unit2) : '0);
      double_seen <= (double_seen & ~erase_mask) |
                     (err_double ? (NUM_UNITS'(1) << unit2) : '0);
    end
  end

  fse_pair_buf u_buf (
    .i_sys_clk   (i_sys_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (st2),
    .i_in_word   (push_word),
    .o_in_ready  (buf_ready),
    .o_out_valid (o_rd_valid),
    .o_out_word  (o_rd_word),
    .i_out_ready (i_rd_out_ready),
    .o_count     (buf_count)
  );

  // ---------------------------------------------------------------------------
  // Reporting: unit status, accumulated status, trap, counter
  // ---------------------------------------------------------------------------
  logic              trap_valid;
  logic [UNIT_W-1:0] stat_unit;

  assign stat_unit = i_stat_addr[UNIT_LSB +: UNIT_W];

  // Reserved bits are built as zero; the double flag is gated by the mode bit.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_stat_valid             <= 1'b0;
      o_data_unit_check_status <= STAT_RESET;
    end else begin
      o_stat_valid <= i_stat_valid; // RULE9
      if (i_stat_valid) begin
        o_data_unit_check_status <= STAT_RESET; // RULE14
        o_data_unit_check_status[UST_DOUBLE_BIT] <= double_seen[stat_unit] && ded_mode; // RULE10
        o_data_unit_check_status[UST_CORR_BIT]   <= single_seen[stat_unit]; // RULE12
        o_data_unit_check_status[UST_OFF_BIT]    <= check_off[stat_unit]; // RULE13
      end
    end
  end

  // An error in the clearing cycle survives the clear.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ecc_status <= STAT_RESET;
    end else begin
      o_ecc_status <= i_clear_status ? STAT_RESET : o_ecc_status; // RULE19
      if (err_single || (i_clear_status ? 1'b0 : o_ecc_status[EST_SINGLE_BIT])) begin
        o_ecc_status[EST_SINGLE_BIT] <= 1'b1; // RULE15
      end
      if (err_double || (i_clear_status ? 1'b0 : o_ecc_status[EST_DOUBLE_BIT])) begin
        o_ecc_status[EST_DOUBLE_BIT] <= 1'b1; // RULE15
      end
    end
  end

  // The trap holds the first failing address; later errors are ignored.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trap_valid  <= 1'b0;
      o_trap_addr <= ADDR_RESET;
    end else if (err_any && (!trap_valid || i_clear_status)) begin
      trap_valid  <= 1'b1; // RULE16
      o_trap_addr <= addr2;
    end else if (i_clear_status) begin
      trap_valid  <= 1'b0; // RULE19
      o_trap_addr <= ADDR_RESET;
    end
  end

  // Saturating counter; correction carries on once it is full.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_err_count <= '0;
    end else if (i_clear_status) begin
      o_err_count <= err_new ? CNT_W'(1) : '0; // RULE19
    end else if (err_new && (o_err_count != CNT_MAX)) begin
      o_err_count <= o_err_count + CNT_W'(1); // RULE17 RULE18
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  cnt_saturate_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE18
    (o_err_count == CNT_MAX) && !i_clear_status |=> (o_err_count == CNT_MAX))
    else $error("error counter left its maximum");

  cnt_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE17
    err_new && !i_clear_status && (o_err_count != CNT_MAX) |=>
    (o_err_count == $past(o_err_count) + CNT_W'(1)))
    else $error("error counter did not step by one");

  cnt_once_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE20
    err_any && counted[unit2] && !i_clear_status |=> $stable(o_err_count))
    else $error("unit counted twice in one transaction");

  trap_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE16
    trap_valid && !i_clear_status |=> trap_valid && $stable(o_trap_addr))
    else $error("trap address changed after capture");

  stat_reserved_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE14
    o_stat_valid |-> (o_data_unit_check_status[7:4] == 4'h0) &&
    !o_data_unit_check_status[2])
    else $error("reserved unit status bits set");

  stat_double_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE10
    i_stat_valid && !ded_mode |=> o_stat_valid && !o_data_unit_check_status[UST_DOUBLE_BIT])
    else $error("double flag shown outside double mode");

  prog_refuse_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE7
    i_prog_valid && ded_mode && prog_repeat |=> o_prog_error && !o_arr_wr_en)
    else $error("repeat program not refused in double mode");

  off_on_repeat_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE5
    i_prog_valid && !ded_mode && prog_repeat && !i_erase_valid |=> check_off[$past(prog_unit)])
    else $error("repeat program left checking on");

  wr_code_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE2
    o_arr_wr_en |-> (o_arr_wr_code[HAM_W-1:0] == wr_code_calc[HAM_W-1:0]))
    else $error("stored code does not match written unit");

  double_status_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE15
    err_double |=> o_ecc_status[EST_DOUBLE_BIT] && o_rd_valid)
    else $error("double error not accumulated or not delivered");

  buf_room_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RULE3
    st2 |-> buf_ready)
    else $error("decoded read word found no room");

endmodule : fse_ecc_core

// ===== dv/fse_array_model.sv
// Array line store behind the check logic, with bit flips injected on read.
module fse_array_model
  import fse_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_wr_en,
  input  wire logic [UNIT_W-1:0] i_wr_unit,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic [CODE_W-1:0] i_wr_code,
  input  wire logic              i_rd_en,
  input  wire logic [UNIT_W-1:0] i_rd_unit,
  input  wire logic [DATA_W-1:0] i_flip,
  output logic      [DATA_W-1:0] o_rd_data,
  output logic      [CODE_W-1:0] o_rd_code
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] mem_data [NUM_UNITS];
  logic [CODE_W-1:0] mem_code [NUM_UNITS];
  // Line and hidden code are kept side by side so a code never strays from its data.
  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem_data[i_wr_unit] <= i_wr_data;
      mem_code[i_wr_unit] <= i_wr_code;
    end
  end
  // Read data is good for one cycle only; elsewhere it toggles so stale values never pass.
  always_ff @(posedge i_sys_clk) begin
    if (i_rd_en) begin
      o_rd_data <= mem_data[i_rd_unit] ^ i_flip;
      o_rd_code <= mem_code[i_rd_unit];
    end else begin
      o_rd_data <= ~o_rd_data;
      o_rd_code <= ~o_rd_code;
    end
  end
endmodule : fse_array_model

// ===== dv/fse_ecc_core_tb.sv
// Self-checking bench for the flash array check logic.
module fse_ecc_core_tb
  import fse_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [DATA_W-1:0] PAT = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
  logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_prog_valid = 1'b0, i_erase_valid = 1'b0;
  logic i_rd_valid = 1'b0, i_rd_start = 1'b0, i_stat_valid = 1'b0, i_clear_status = 1'b0;
  logic i_rd_out_ready = 1'b1, o_prog_done, o_prog_error, o_arr_wr_en, o_rd_ready;
  logic o_arr_rd_en, o_rd_valid, o_stat_valid;
  logic [STAT_W-1:0]     i_config_reg4_volatile = 8'h08, o_data_unit_check_status, o_ecc_status;
  logic [ADDR_W-1:0]     i_prog_addr = '0, i_rd_addr = '0, i_stat_addr = '0, o_trap_addr;
  logic [DATA_W-1:0]     i_prog_data = '0, flip = '0, i_arr_rd_data, o_arr_wr_data;
  logic [UNIT_BYTES-1:0] i_prog_bmask = '1;
  logic [SEC_W-1:0]      i_erase_sector = '0;
  logic [CODE_W-1:0]     o_arr_wr_code, i_arr_rd_code;
  logic [UNIT_W-1:0]     o_arr_wr_unit, o_arr_rd_unit;
  logic [CNT_W-1:0]      o_err_count;
  fse_rd_word_t          o_rd_word;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  fse_ecc_core dut_u (
    .i_sys_clk, .i_arst_n, .i_config_reg4_volatile, .i_prog_valid, .i_prog_addr,
    .i_prog_data, .i_prog_bmask, .o_prog_done, .o_prog_error, .o_arr_wr_en,
    .o_arr_wr_unit, .o_arr_wr_data, .o_arr_wr_code, .i_erase_valid, .i_erase_sector,
    .i_rd_valid, .i_rd_start, .i_rd_addr, .o_rd_ready, .o_arr_rd_en, .o_arr_rd_unit,
    .i_arr_rd_data, .i_arr_rd_code, .o_rd_valid, .o_rd_word, .i_rd_out_ready,
    .i_stat_valid, .i_stat_addr, .o_stat_valid, .o_data_unit_check_status,
    .i_clear_status, .o_ecc_status, .o_trap_addr, .o_err_count);
  fse_array_model arr_u (.i_sys_clk, .i_wr_en(o_arr_wr_en), .i_wr_unit(o_arr_wr_unit),
    .i_wr_data(o_arr_wr_data), .i_wr_code(o_arr_wr_code), .i_rd_en(o_arr_rd_en),
    .i_rd_unit(o_arr_rd_unit), .i_flip(flip), .o_rd_data(i_arr_rd_data),
    .o_rd_code(i_arr_rd_code));
  always #2 i_sys_clk = ~i_sys_clk;
  // Cuts a hung run short; the whole sequence needs well under a thousand cycles.
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // Case equality so an unknown never passes for a match.
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // Inputs always change one nanosecond after the edge, clear of the sampling point.
  task automatic tick();
    @(posedge i_sys_clk);
    #1;
  endtask : tick
  task automatic prog(input logic [ADDR_W-1:0] a, input logic err);
    i_prog_valid = 1'b1;
    i_prog_addr = a;
    i_prog_data = PAT;
    tick();
    i_prog_valid = 1'b0;
    chk(o_prog_error, err);
    chk(o_prog_done, !err);
    chk(o_arr_wr_data, PAT);
    chk(o_arr_wr_en, !err);
  endtask : prog
  task automatic rd(input logic [ADDR_W-1:0] a, input logic st);
    while (o_rd_ready !== 1'b1) tick();
    i_rd_valid = 1'b1;
    i_rd_addr = a;
    i_rd_start = st;
    tick();
    i_rd_valid = 1'b0;
  endtask : rd
  // A double error returns the raw line, anything else the repaired data.
  task automatic get(input logic [1:0] errs);
    while (o_rd_valid !== 1'b1) tick();
    chk(o_rd_word.data, errs[0] ? PAT ^ flip : PAT);
    chk({o_rd_word.single_err, o_rd_word.double_err}, errs);
    tick();
  endtask : get
  task automatic stat(input logic [ADDR_W-1:0] a, input logic [STAT_W-1:0] e);
    i_stat_valid = 1'b1;
    i_stat_addr = a;
    tick();
    i_stat_valid = 1'b0;
    chk(o_stat_valid, 1'b1);
    chk(o_data_unit_check_status, e);
  endtask : stat
  task automatic er(input logic [SEC_W-1:0] s);
    i_erase_valid = 1'b1;
    i_erase_sector = s;
    tick();
    i_erase_valid = 1'b0;
  endtask : er
  task automatic t_single();
    prog(32'h10, 1'b0);
    rd(32'h10, 1'b1);
    get(2'b00);
    flip = 128'h20;
    rd(32'h10, 1'b1);
    get(2'b10);
    stat(32'h10, 8'h02);
    chk(o_ecc_status, 8'h08);
    chk(o_trap_addr, 32'h10);
    chk(o_err_count, 16'h1);
  endtask : t_single
  // Same unit read twice in one transaction counts once, then again in a new one.
  task automatic t_double();
    flip = 128'h3;
    prog(32'h20, 1'b0);
    rd(32'h20, 1'b1);
    get(2'b01);
    rd(32'h20, 1'b0);
    get(2'b01);
    chk(o_err_count, 16'h2);
    rd(32'h20, 1'b1);
    get(2'b01);
    chk(o_err_count, 16'h3);
    stat(32'h20, 8'h08);
    chk(o_ecc_status, 8'h18);
    chk(o_trap_addr, 32'h10);
  endtask : t_double
  task automatic t_repeat();
    prog(32'h10, 1'b1);
    stat(32'h10, 8'h02);
    i_clear_status = 1'b1;
    tick();
    i_clear_status = 1'b0;
    tick();
    chk(o_ecc_status, 8'h00);
    chk(o_trap_addr, 32'h0);
    chk(o_err_count, 16'h0);
  endtask : t_repeat
  // Every sector is wiped before the mode changes, since old codes become meaningless.
  task automatic t_mode();
    flip = '0;
    for (int s = 0; s < 4; s++) er(s[SEC_W-1:0]);
    i_config_reg4_volatile = 8'h00;
    prog(32'h30, 1'b0);
    prog(32'h30, 1'b0);
    stat(32'h30, 8'h01);
    stat(32'h20, 8'h00);
    er(2'h0);
    stat(32'h30, 8'h00);
  endtask : t_mode
  // The receiver stalls until both entries are full, then drains them in order.
  task automatic t_stall();
    i_rd_out_ready = 1'b0;
    prog(32'h40, 1'b0);
    rd(32'h40, 1'b1);
    rd(32'h40, 1'b0);
    repeat (4) tick();
    chk(o_rd_ready, 1'b0);
    chk(o_rd_valid, 1'b1);
    i_rd_out_ready = 1'b1;
    get(2'b00);
    get(2'b00);
  endtask : t_stall
  initial begin
    repeat (5) @(posedge i_sys_clk);
    #1 i_arst_n = 1'b1;
    tick();
    t_single();
    t_double();
    t_repeat();
    t_mode();
    t_stall();
    give_verdict();
  end
endmodule : fse_ecc_core_tb
